// ==== cps_card_power_sequencer_irq.sv ====
// two-card power sequencer with extraction filter and interrupt pin
// assumes a decoded command byte strobed once per chip-select frame,
// all card-side inputs and the pull-up, host io and address pins
// asynchronous to the core clock; mode and clock-run come from core logic
module cps_card_power_sequencer_irq
    import cps_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_cs_n,               // chip select, active low
    input wire logic i_cmd_valid,          // one-cycle strobe, command latched
    input wire logic [7:0] i_cmd,          // latched command byte
    input wire logic i_chip_addr_pin,      // chip address strap
    input wire logic i_sync_mode,          // 1: synchronous card protocol
    input wire logic i_host_io,            // host io pin level
    input wire logic i_pullup_select,      // pull-up select pin
    input wire logic [1:0] i_card_presence_switch, // 1 = card present
    input wire logic [1:0] i_supply_good,  // supply above minimum
    input wire logic [1:0] i_supply_fault, // supply out of window
    input wire logic [1:0] i_card_io_in,   // card io level
    input wire logic [1:0] i_aux_four_in,
    input wire logic [1:0] i_aux_eight_in,
    input wire logic [1:0] i_clock_run,    // host wants card clock running
    output logic [1:0] o_card_supply,      // converter enable
    output logic [1:0] o_card_reset_line,
    output logic [1:0] o_card_clock_en,    // clock gate, low forces line low
    output logic [1:0] o_aux_contact_four,
    output logic [1:0] o_aux_contact_eight,
    output logic [1:0] o_card_io_line,     // 0 drives low, 1 releases
    output logic [1:0] o_pullup_on,
    output logic [7:0] o_response,         // response byte
    output logic o_irq_n                   // interrupt, active low
);
    // =====================================================
    // input synchronisers, three stages, change when 2nd and 3rd agree
    localparam int NSYNC = 15;            // twelve card bits and three host-side pins
    // idle levels: pull-up selected and host io released, the rest low,
    // so that reset does not show a false change on the pull-up output
    localparam logic [NSYNC-1:0] SYNC_IDLE = {2'h3, {(NSYNC - 2){1'h0}}};
    logic [NSYNC-1:0] s1, s2, s3, sv;     // sampler stages and accepted value
    logic [NSYNC-1:0] raw;                // pins as they arrive
    logic [NSYNC-1:0] agree;              // 2nd and 3rd stage match
    assign raw = {i_pullup_select, i_host_io, i_chip_addr_pin, i_card_presence_switch,
                  i_supply_good, i_supply_fault, i_card_io_in, i_aux_four_in, i_aux_eight_in};
    assign agree = ~(s2 ^ s3);
    // three-stage sampler
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s1 <= SYNC_IDLE;
            s2 <= SYNC_IDLE;
            s3 <= SYNC_IDLE;
            sv <= SYNC_IDLE;
        end
        else
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            // accept only settled bits, a bit that still moves keeps its old value
            sv <= (s2 & agree) | (sv & ~agree);
        end
    end
    logic pullup_pin, host_io_pin, chip_addr;               // settled host-side pins
    logic [1:0] det_raw, good, fault, io_in, c4_in, c8_in;   // settled card bits
    assign {pullup_pin, host_io_pin, chip_addr,
            det_raw, good, fault, io_in, c4_in, c8_in} = sv;

    // =====================================================
    // command decode; ignored entirely while chip select is high
    logic cmd_ok;
    logic cmd_card;
    logic [1:0] cmd_sup;
    assign cmd_ok = i_cmd_valid && !i_cs_n && !i_cmd[CMD_ADDR_MSB];
    assign cmd_card = i_cmd[CMD_CARD_BIT];
    assign cmd_sup = {i_cmd[CMD_SUP_HI], i_cmd[CMD_SUP_LO]};
    logic chip_hit;
    assign chip_hit = cmd_ok && (i_cmd[CMD_CHIP_BIT] == chip_addr);

    // =====================================================
    // per-card logic
    cps_state_t st [2];                   // sequencer state per card
    logic [CNT_W-1:0] step_cnt [2];       // power-down step timer
    logic [CNT_W-1:0] filt_cnt [2];       // presence filter timer
    logic [1:0] det;                      // filtered presence
    logic [1:0] pend_ins, pend_ext, pend_ovl;   // sticky interrupt sources
    logic [1:0] rst_reg;                  // reset level from the last addressed command
    logic [1:0] io_sync_data;             // card io level in synchronous mode

    // aux contacts stay up in session and through the first two power-down steps
    function automatic logic aux_held(input cps_state_t s);
        return (s == CPS_ON) || (s == CPS_D_CLK) || (s == CPS_D_AUX);
    endfunction : aux_held

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_card
            logic sel;
            logic prog_on, prog_off;
            logic ext_evt, ins_evt;
            assign sel = chip_hit && (cmd_card == 1'(g));
            assign prog_on = sel && (cmd_sup != SUP_OFF);
            assign prog_off = sel && (cmd_sup == SUP_OFF);
            assign ext_evt = det[g] && !det_raw[g] && (filt_cnt[g] == CNT_W'(FILT_CYC));
            assign ins_evt = !det[g] && det_raw[g] && (filt_cnt[g] == CNT_W'(FILT_CYC));

            // presence filter: level must stand for the whole interval
            always_ff @(posedge i_clock or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    filt_cnt[g] <= '0;
                    det[g] <= 1'b0;
                end
                else if (det_raw[g] == det[g])
                begin
                    filt_cnt[g] <= '0;
                end
                else if (filt_cnt[g] == CNT_W'(FILT_CYC))
                begin
                    det[g] <= det_raw[g];
                    filt_cnt[g] <= '0;
                end
                else
                begin
                    filt_cnt[g] <= filt_cnt[g] + 1'b1;
                end
            end

            // sticky pending flags; a set beats a same-cycle clear
            always_ff @(posedge i_clock or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    pend_ins[g] <= 1'b0;
                    pend_ext[g] <= 1'b0;
                    pend_ovl[g] <= 1'b0;
                end
                else
                begin
                    pend_ins[g] <= ins_evt | (pend_ins[g] & ~prog_on);
                    pend_ext[g] <= ext_evt | (pend_ext[g] & ~prog_off);
                    pend_ovl[g] <= (fault[g] & o_card_supply[g])
                                   | (pend_ovl[g] & ~prog_off);
                end
            end

            // sequencer
            always_ff @(posedge i_clock or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    st[g] <= CPS_OFF;
                    step_cnt[g] <= '0;
                    rst_reg[g] <= 1'b0;
                    io_sync_data[g] <= 1'b1;
                end
                else
                begin
                    // reset line and sync io data follow the addressed command
                    if (sel)
                    begin
                        rst_reg[g] <= i_cmd[CMD_RST_BIT];
                        io_sync_data[g] <= i_cmd[CMD_IO_BIT];
                    end
                    unique case (st[g])
                        CPS_OFF:
                        begin
                            if (prog_on)
                            begin
                                st[g] <= CPS_RAMP;
                            end
                        end
                        CPS_RAMP, CPS_ON:
                        begin
                            // request, extraction or fault starts the shutdown
                            if (prog_off || ext_evt || fault[g])
                            begin
                                st[g] <= CPS_D_CLK;
                                step_cnt[g] <= '0;
                            end
                            else if (st[g] == CPS_RAMP && good[g])
                            begin
                                st[g] <= CPS_ON;
                            end
                        end
                        CPS_D_CLK, CPS_D_AUX:
                        begin
                            if (step_cnt[g] == CNT_W'(STEP_CYC - 1))
                            begin
                                step_cnt[g] <= '0;
                                // reset, then clock, then aux, one interval apart
                                if (st[g] == CPS_D_CLK)
                                begin
                                    st[g] <= CPS_D_AUX;
                                end
                                else
                                begin
                                    st[g] <= CPS_D_IO;
                                end
                            end
                            else
                            begin
                                step_cnt[g] <= step_cnt[g] + 1'b1;
                            end
                        end
                        CPS_D_IO:
                        begin
                            // io drops after one interval and the supply after the
                            // next, so this last state spans two intervals
                            if (step_cnt[g] == CNT_W'(STEP_CYC + STEP_CYC - 1))
                            begin
                                step_cnt[g] <= '0;
                                st[g] <= CPS_OFF;
                            end
                            else
                            begin
                                step_cnt[g] <= step_cnt[g] + 1'b1;
                            end
                        end
                    endcase
                end
            end

            // card contact outputs, registered from the current state and step
            always_ff @(posedge i_clock or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    o_card_supply[g] <= 1'b0;
                    o_card_reset_line[g] <= 1'b0;
                    o_card_clock_en[g] <= 1'b0;
                    o_aux_contact_four[g] <= 1'b0;
                    o_aux_contact_eight[g] <= 1'b0;
                    o_card_io_line[g] <= 1'b0;
                    o_pullup_on[g] <= 1'b1;
                end
                else
                begin
                    o_pullup_on[g] <= pullup_pin;
                    // a fault cuts the converter at once; once cut it stays off until
                    // the sequence ends, even if the fault goes away meanwhile
                    o_card_supply[g] <= !fault[g]
                        && ((st[g] == CPS_RAMP) || (st[g] == CPS_ON)
                        || ((st[g] != CPS_OFF) && o_card_supply[g]));
                    // contacts low while ramping or off
                    o_card_reset_line[g] <= (st[g] == CPS_ON) && rst_reg[g];
                    // a clock already low in session stays low through the shutdown
                    o_card_clock_en[g] <= ((st[g] == CPS_ON) && i_clock_run[g])
                                          || ((st[g] == CPS_D_CLK) && o_card_clock_en[g]);
                    o_aux_contact_four[g] <= aux_held(st[g]);
                    o_aux_contact_eight[g] <= aux_held(st[g]);
                    // io path valid only with chip select low
                    if (st[g] == CPS_ON)
                    begin
                        o_card_io_line[g] <= i_cs_n ? 1'b1
                                             : (i_sync_mode ? io_sync_data[g] : host_io_pin);
                    end
                    else if (aux_held(st[g])
                             || ((st[g] == CPS_D_IO) && (step_cnt[g] < CNT_W'(STEP_CYC))))
                    begin
                        o_card_io_line[g] <= 1'b1;   // released until its own step
                    end
                    else
                    begin
                        o_card_io_line[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // =====================================================
    // response byte: status of the addressed card, captured at the command
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_response <= 8'h00;
        end
        else if (chip_hit)
        begin
            o_response <= '0;
            o_response[RSP_DET] <= det[cmd_card];
            o_response[RSP_IO] <= io_in[cmd_card];
            o_response[RSP_C4] <= c4_in[cmd_card];
            o_response[RSP_C8] <= c8_in[cmd_card];
            o_response[RSP_GOOD] <= good[cmd_card];
        end
    end

    // =====================================================
    // interrupt pin, never gated by select or address
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_irq_n <= 1'b1;
        end
        else
        begin
            o_irq_n <= ~(|{pend_ins, pend_ext, pend_ovl});
        end
    end
endmodule : cps_card_power_sequencer_irq

// ==== cps_checker.sv ====
// port assertions for the card power sequencer, card A side
// assumes one core clock and the async active-low reset of the block
module cps_checker
    import cps_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd,
    input wire logic i_chip_addr_pin,
    input wire logic i_pullup_select,
    input wire logic [1:0] i_card_presence_switch,
    input wire logic [1:0] i_supply_fault,
    input wire logic [1:0] o_card_supply,
    input wire logic [1:0] o_card_reset_line,
    input wire logic [1:0] o_card_clock_en,
    input wire logic [1:0] o_aux_contact_four,
    input wire logic [1:0] o_aux_contact_eight,
    input wire logic [1:0] o_pullup_on,
    input wire logic [7:0] o_response,
    input wire logic o_irq_n
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    logic took; // command accepted at this edge
    int unsigned since; // cycles since the card A switch moved, saturating
    assign took = i_cmd_valid && !i_cs_n && !i_cmd[7] && (i_cmd[6] == i_chip_addr_pin);
    // a counter, since the filter is far longer than any delay range
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            since <= 0;
        else if ($changed(i_card_presence_switch[0]))
            since <= 1;
        else if (since != 0 && since < 100000)
            since <= since + 1;
    end
    rst_idle_a: assert property (
        $rose(i_rstn) |-> o_irq_n && o_card_supply == 2'h0)
        else $error("outputs not idle after reset");
    ramp_low_a: assert property (
        $rose(o_card_supply[0]) |-> !o_card_reset_line[0] && !o_card_clock_en[0]
            && !o_aux_contact_four[0] && !o_aux_contact_eight[0])
        else $error("contact high as supply rises");
    down_order_a: assert property (
        $fell(o_card_supply[0]) && !i_supply_fault[0] |-> !o_card_reset_line[0]
            && !o_card_clock_en[0] && !o_aux_contact_four[0] && !o_aux_contact_eight[0])
        else $error("supply off before contacts");
    step_gap_a: assert property (
        $fell(o_card_supply[0]) && !i_supply_fault[0] |-> !$past(o_card_reset_line[0], 90))
        else $error("power-down steps too short");
    pullup_on_a: assert property (
        i_pullup_select [*6] |-> o_pullup_on == 2'h3)
        else $error("pull-up off while selected");
    pullup_off_a: assert property (
        !i_pullup_select [*6] |-> o_pullup_on == 2'h0)
        else $error("pull-up on while deselected");
    refuse_cmd_a: assert property (
        i_cmd_valid && !took |=> $stable(o_response))
        else $error("refused command changed response");
    fault_off_a: assert property (
        $rose(i_supply_fault[0]) && o_card_supply[0] |-> ##[1:8] !o_card_supply[0] && !o_irq_n)
        else $error("fault did not drop supply");
    host_down_a: assert property (
        took && !i_cmd[5] && i_cmd[1:0] == SUP_OFF && o_card_supply[0]
            |-> ##[1:3] !o_card_reset_line[0])
        else $error("host power-down late");
    filt_irq_a: assert property (
        since == FILT_CYC + 12 |-> !o_irq_n)
        else $error("no interrupt after filtered card move");
    cover property (took && i_cmd[1:0] == SUP_OFF && o_card_supply[0]);
    cover property ($rose(i_supply_fault[0]) && o_card_supply[0]);
    cover property ($fell(o_irq_n));
endmodule : cps_checker
bind cps_card_power_sequencer_irq cps_checker u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_cs_n(i_cs_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_chip_addr_pin(i_chip_addr_pin), .i_pullup_select(i_pullup_select),
    .i_card_presence_switch(i_card_presence_switch), .i_supply_fault(i_supply_fault),
    .o_card_supply(o_card_supply), .o_card_reset_line(o_card_reset_line),
    .o_card_clock_en(o_card_clock_en), .o_aux_contact_four(o_aux_contact_four),
    .o_aux_contact_eight(o_aux_contact_eight), .o_pullup_on(o_pullup_on),
    .o_response(o_response), .o_irq_n(o_irq_n));

// ==== cps_host_model.sv ====
// host model: one command byte per chip-select frame
// assumes callers run on the falling clock edge
module cps_host_model
(
    input wire logic i_clock,
    output logic o_cs_n,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic keep_n = 1'b1; // chip select level between frames
    initial
    begin
        o_cs_n = 1'b1;
        o_cmd_valid = 1'b0;
        o_cmd = 8'h00;
    end
    // set the select level held between frames; low lets host io pass
    task automatic select(input logic v);
        @(negedge i_clock);
        keep_n = v;
        o_cs_n = v;
    endtask : select
    // stale byte inverted after the strobe so it never looks valid
    task automatic send(input logic [7:0] b);
        @(negedge i_clock);
        o_cs_n = 1'b0;
        @(negedge i_clock);
        o_cmd_valid = 1'b1;
        o_cmd = b;
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        o_cmd = ~b;
        o_cs_n = keep_n;
    endtask : send
endmodule : cps_host_model

// ==== cps_pkg.sv ====
// constants for the per-card power sequencer and interrupt logic
// assumes one 100 MHz core clock and an async active-low power-on reset
// How it works
// - supply out of window: converter off, power-down, interrupt
// - contacts held low until supply reaches minimum
// - power-down starts on request, extraction or overload
// - order: reset, clock, aux contacts, io, supply
// - steps spaced by 500 ns
// - extraction filtered 50 us; host request immediate
// - card io from host pin or command bit 2
// - pull-up enabled when select pin is high
// - io transaction valid only with chip select low
// - interrupt output high after power-on reset
// - interrupt low on insertion, extraction or fault
// - interrupt not qualified by select or address
// - nonzero supply code clears insertion interrupt
// - zero supply code clears extraction or overload
// - reinsertion before acknowledge keeps interrupt low
// - chip select high: all programming ignored
// - response bits: detect, io, aux four, aux eight, good
package cps_pkg;
    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;          // core clock period
    localparam int STEP_NS = 500;               // power-down step spacing
    localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_US = 50;                // insertion/extraction filter
    localparam int FILT_CYC = (FILT_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;                  // counter width
    // =====================================================
    // command byte layout
    localparam int CMD_ADDR_MSB = 7;            // top address bit
    localparam int CMD_CHIP_BIT = 6;            // chip address bit
    localparam int CMD_CARD_BIT = 5;            // card select bit
    localparam int CMD_RST_BIT = 4;             // card reset value
    localparam int CMD_IO_BIT = 2;              // sync card io data
    localparam int CMD_SUP_HI = 1;              // supply code high bit
    localparam int CMD_SUP_LO = 0;              // supply code low bit
    localparam logic [1:0] SUP_OFF = 2'h0;      // zero volt code
    // response byte layout
    localparam int RSP_DET = 4;
    localparam int RSP_IO = 3;
    localparam int RSP_C4 = 2;
    localparam int RSP_C8 = 1;
    localparam int RSP_GOOD = 0;
    // =====================================================
    // power sequencer states
    typedef enum logic [5:0] {
        CPS_OFF   = 6'h01,   // supply off, contacts low
        CPS_RAMP  = 6'h02,   // supply rising, contacts held low
        CPS_ON    = 6'h04,   // contacts follow host
        CPS_D_CLK = 6'h08,   // reset low, clock next
        CPS_D_AUX = 6'h10,   // clock low, aux next
        CPS_D_IO  = 6'h20    // aux low, io next then supply
    } cps_state_t;
endpackage : cps_pkg

// ==== test_card_power_sequencer_irq.sv ====
// bench: card levels from here, host frames through the host model
// assumes chip address strap low, card A exercised
module test_card_power_sequencer_irq;
    timeunit 1ns;
    timeprecision 1ns;
    import cps_pkg::*;
    logic i_clock = 0, i_rstn, i_sync_mode, i_host_io, i_pullup_select;
    logic i_cs_n, i_cmd_valid, o_irq_n, took = 0, took2 = 0;
    logic [7:0] i_cmd, o_response;
    logic [7:0] exp_q[$];
    logic [1:0] pres, good, fault, io_in, c4_in, c8_in, run;
    logic [1:0] sup, rst_l, clk_en, c4, c8, io, pu;
    int err_count = 0, comparisons = 0, cyc = 0;
    cps_host_model u_host (.i_clock(i_clock), .o_cs_n(i_cs_n), .o_cmd_valid(i_cmd_valid),
        .o_cmd(i_cmd));
    cps_card_power_sequencer_irq u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_cs_n(i_cs_n),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_chip_addr_pin(1'b0),
        .i_sync_mode(i_sync_mode), .i_host_io(i_host_io), .i_pullup_select(i_pullup_select),
        .i_card_presence_switch(pres), .i_supply_good(good), .i_supply_fault(fault),
        .i_card_io_in(io_in), .i_aux_four_in(c4_in), .i_aux_eight_in(c8_in),
        .i_clock_run(run), .o_card_supply(sup), .o_card_reset_line(rst_l),
        .o_card_clock_en(clk_en), .o_aux_contact_four(c4), .o_aux_contact_eight(c8),
        .o_card_io_line(io), .o_pullup_on(pu), .o_response(o_response), .o_irq_n(o_irq_n));
    // ==========================================
    // clock, timeout and response monitor
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cyc++;
        took <= i_cmd_valid && !i_cs_n && !i_cmd[7] && !i_cmd[6];
        took2 <= took;
        if (cyc == 30000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    // the answer lands at the strobe edge and is checked at the second falling edge after it
    always @(negedge i_clock)
    begin
        if (took2)
            check(o_response, exp_q.pop_front());
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge i_clock);
    endtask : idle
    // fresh card levels settle past the synchronisers before the frame
    task automatic cmd(input logic [7:0] b);
        @(negedge i_clock);
        io_in = 2'($urandom);
        c4_in = 2'($urandom);
        c8_in = 2'($urandom);
        idle(6);
        if (!b[7] && !b[6])
            exp_q.push_back({3'h0, pres[b[5]], io_in[b[5]], c4_in[b[5]], c8_in[b[5]], good[b[5]]});
        u_host.send(b);
    endtask : cmd
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(41));
        {i_rstn, i_sync_mode, i_host_io, i_pullup_select} = 4'h3;
        {pres, good, fault, io_in, c4_in, c8_in, run} = 14'h0003;
        idle(6);
        i_rstn = 1'b1;
        idle(2);
        check(o_irq_n, 1'b1);
        check(pu, 2'h3);
        i_pullup_select = 1'b0;
        idle(8);
        check(pu, 2'h0);
        i_pullup_select = 1'b1;
        $display("reset and pull-up test done");
        pres[0] = 1'b1;
        idle(FILT_CYC - 200);
        check(o_irq_n, 1'b1);
        idle(250);
        check(o_irq_n, 1'b0);
        cmd(8'h83);
        cmd(8'h43);
        check(o_irq_n, 1'b0);
        cmd(8'h13);
        idle(3);
        check(o_irq_n, 1'b1);
        check({sup[0], rst_l[0]}, 2'h2);
        good[0] = 1'b1;
        idle(8);
        check(rst_l[0], 1'b1);
        u_host.select(1'b0);
        i_host_io = 1'b0;
        idle(8);
        check(io[0], 1'b0);
        i_sync_mode = 1'b1;
        cmd(8'h17);
        idle(3);
        check(io[0], 1'b1);
        u_host.select(1'b1);
        i_sync_mode = 1'b0;
        idle(8);
        check(io[0], 1'b1);
        cmd(8'h20);
        $display("power-up test done");
        cmd(8'h10);
        idle(4);
        check({sup[0], rst_l[0], clk_en[0]}, 3'h5);
        idle(2 * STEP_CYC);
        check(sup[0], 1'b1);
        check({c4[0], c8[0], io[0]}, 3'h1);
        idle(2 * STEP_CYC);
        check({sup[0], clk_en[0], io[0]}, 3'h0);
        good[0] = 1'b0;
        $display("host power-down test done");
        cmd(8'h13);
        good[0] = 1'b1;
        idle(8);
        pres[0] = 1'b0;
        idle(FILT_CYC - 200);
        check(sup[0], 1'b1);
        idle(500);
        check({sup[0], o_irq_n}, 2'h0);
        good[0] = 1'b0;
        pres[0] = 1'b1;
        idle(FILT_CYC + 50);
        check(o_irq_n, 1'b0);
        cmd(8'h00);
        idle(3);
        check(o_irq_n, 1'b0);
        cmd(8'h03);
        idle(3);
        check(o_irq_n, 1'b1);
        $display("extraction test done");
        good[0] = 1'b1;
        idle(8);
        fault[0] = 1'b1;
        idle(10);
        check({sup[0], o_irq_n}, 2'h0);
        idle(200);
        {fault[0], good[0]} = 2'h0;
        cmd(8'h00);
        idle(3);
        check(o_irq_n, 1'b1);
        $display("overload test done");
        report_and_stop();
    end
endmodule : test_card_power_sequencer_irq
